/* hw/ubc_baud.v */
// baud tick generator: count source select and eight-bit divider
module ubc_baud (
	// clock and reset
	input  wire       sys_clk,
	input  wire       rst,
	// configuration
	input  wire [1:0] countSource,
	input  wire [7:0] baudDivider,
	input  wire       useExtClk,
	input  wire       extEdge,
	// sixteen-times bit rate enable
	output reg        bitTick
);

	reg  [4:0] preCnt_q;   // free prescaler for f2, f8, f32
	reg  [7:0] divCnt_q;   // down counter of the divider
	reg        srcTick;    // selected count source pulse

	// count source choice, external edge replaces it
	always @*
	begin
		srcTick = 1'b0;
		if (useExtClk)
			srcTick = extEdge;
		else
		begin
			case (countSource)
				2'h0: srcTick = 1'b1;
				2'h1: srcTick = preCnt_q[0];
				2'h2: srcTick = &preCnt_q[2:0];
				2'h3: srcTick = &preCnt_q[4:0];
				default: srcTick = 1'b0;
			endcase
		end
	end

	// prescaler and divide by (n+1)
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			preCnt_q <= 5'h00;
			divCnt_q <= 8'h00;
			bitTick  <= 1'b0;
		end
		else
		begin
			preCnt_q <= preCnt_q + 5'h01;
			bitTick  <= 1'b0;
			if (srcTick)
			begin
				if (divCnt_q == 8'h00)
				begin
					divCnt_q <= baudDivider;
					bitTick  <= 1'b1;
				end
				else
					divCnt_q <= divCnt_q - 8'h01;
			end
		end
	end

endmodule

/* hw/ubc_defs.vh */
// constants, register map and field positions of the bus collision uart
// Operation
// - four clock phase/polarity combinations in sync mode
// - mode 110b selects bus mode with nine data bits per character
// - tx level differing from rx raises collision
// - nine-bit buffers with overrun, framing, parity, sum
// - software picks the collision sampling instant
// - auto-clear of transmit enable on collision
// - selectable transmit start condition
// - optional inversion of tx and rx lines in uart modes
// - bit clock internal or external by direction bit
// - flow disable set makes flow pin select ignored
// - tx pin push-pull or open-drain
// - tx interrupt cause selectable per channel
// - two-bit count source, eight-bit divider
// - flags for shift register and buffer empty
// - reception complete flag after buffer load
// - overrun keeps buffer, no receive request
`ifndef UBC_DEFS_VH
`define UBC_DEFS_VH

// register byte offsets
`define UBC_OFF_TXBUF  8'h00
`define UBC_OFF_RXBUF  8'h04
`define UBC_OFF_BAUD   8'h08
`define UBC_OFF_MODE   8'h0C
`define UBC_OFF_CTRL0  8'h10
`define UBC_OFF_CTRL1  8'h14
`define UBC_OFF_SPEC   8'h18
`define UBC_OFF_IRQSEL 8'h1C
`define UBC_OFF_STAT   8'h20
`define UBC_OFF_SHARED 8'h24

// mode select field codes
`define UBC_MODE_SYNC  3'h1
`define UBC_MODE_BUS   3'h6

// channel mode register fields
`define UBC_MR_CLKDIR  3
`define UBC_MR_STOP2   4
`define UBC_MR_PRY     5
`define UBC_MR_PARITY_ENABLE    6
`define UBC_MR_LINE_POLARITY_INVERT   7

// channel control 0 fields
`define UBC_C0_CRS     2
`define UBC_C0_TX_SHIFT_EMPTY   3
`define UBC_C0_CRD     4
`define UBC_C0_NCH     5
`define UBC_C0_CLOCK_POLARITY_SELECT   6

// channel control 1 fields
`define UBC_C1_TE      0
`define UBC_C1_TI      1
`define UBC_C1_RE      2
`define UBC_C1_RI      3
`define UBC_C1_IRS     4

// special mode fields
`define UBC_SP_COLLISION_SAMPLE_TIMING   4
`define UBC_SP_TX_ENABLE_AUTOCLEAR    5
`define UBC_SP_SSS     6
`define UBC_SP_CLOCK_PHASE_SELECT    9

// irq source select: channel 0 and 1 collision enables
`define UBC_IS_CH0     6
`define UBC_IS_CH1     7

// reset values
`define UBC_RST_BYTE   8'h00
`define UBC_RST_WORD9  9'h000

// bit timing in baud ticks (16 ticks per bit)
`define UBC_TICK_MID   4'h8
`define UBC_TICK_LAST  4'hF

`endif

/* hw/ubc_uart.v */
// one serial channel with bus collision mode behind an apb slave
`include "ubc_defs.vh"
module ubc_uart #(
	parameter CHANNEL = 2
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// apb slave
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// serial pins
	input  wire        serialRxPin,
	output reg         serialTxOut,
	output reg         serialTxOe,
	// transfer clock pin
	input  wire        clkPinIn,
	output reg         clkPinOut,
	output wire        clkPinOe,
	// flow control pin
	input  wire        flowPinIn,
	output wire        flowPinOut,
	output wire        flowPinOe,
	// interrupt requests
	output reg         txIrq,
	output reg         rxIrq,
	output reg         collisionIrq
);

	localparam TX_IDLE  = 2'h0;
	localparam TX_WAIT  = 2'h1;
	localparam TX_SHIFT = 2'h2;
	localparam RX_IDLE  = 1'b0;
	localparam RX_RUN   = 1'b1;

	// software registers
	reg  [8:0]  txBuf_q;       // transmit buffer
	reg  [8:0]  rxBuf_q;       // receive buffer
	reg  [7:0]  baudDiv_q;     // baud divider
	reg  [7:0]  modeReg_q;     // channel mode register
	reg  [7:0]  ctrl0_q;       // channel control 0 (bit 3 unused)
	reg         txEn_q;        // transmit enable
	reg         rxEn_q;        // receive enable
	reg         txCause2_q;    // tx irq cause, own bit
	reg         sampleSel_q;   // collision sample timing
	reg         autoClr_q;     // tx enable auto-clear
	reg         startCond_q;   // tx start condition
	reg         phase_q;       // clock phase select
	reg  [1:0]  irqSel_q;      // ch0/ch1 collision enables
	reg  [1:0]  sharedCause_q; // ch0/ch1 tx irq causes
	// status flags
	reg         txBufEmpty_q;  // transmit buffer empty
	reg         rxDone_q;      // reception complete
	reg         ovr_q;         // overrun
	reg         frm_q;         // framing error
	reg         par_q;         // parity error
	reg         collFlag_q;    // sticky collision seen
	// synchronisers: rx, clock pin, flow pin
	reg  [2:0]  syncA_q;
	reg  [2:0]  syncB_q;
	reg         rxPrev_q;      // rx level one cycle back
	reg         clkPrev_q;     // clock pin one cycle back
	// transmitter
	reg  [1:0]  txState_q;
	reg  [12:0] txShift_q;
	reg  [3:0]  txLeft_q;
	reg  [3:0]  txTick_q;
	// receiver
	reg         rxState_q;
	reg  [12:0] rxShift_q;
	reg  [3:0]  rxIdx_q;
	reg  [3:0]  rxTick_q;

	// decoded fields and helpers
	wire        bitTick;
	wire [2:0]  modeSel  = modeReg_q[2:0];
	wire        isBus    = modeSel == `UBC_MODE_BUS;
	wire        isSync   = modeSel == `UBC_MODE_SYNC;
	wire        isUart   = modeSel[2];
	wire        clkDir   = modeReg_q[`UBC_MR_CLKDIR];
	wire        parity_enable     = modeReg_q[`UBC_MR_PARITY_ENABLE];
	wire        invert   = modeReg_q[`UBC_MR_LINE_POLARITY_INVERT] & isUart;
	wire        flowOff  = ctrl0_q[`UBC_C0_CRD];
	wire        flowRts  = ctrl0_q[`UBC_C0_CRS];
	wire [3:0]  dataBits = isBus ? 4'h9 : 4'h8;
	wire        rxLevel  = syncB_q[0] ^ invert;
	wire        rxFall   = rxPrev_q & ~rxLevel;
	wire        extEdge  = syncB_q[1] & ~clkPrev_q;
	wire        setupPh  = psel & ~penable;
	wire        wrAcc    = psel & penable & pwrite;
	wire        rdAcc    = psel & penable & ~pwrite;
	wire        txBufWr  = wrAcc & (paddr == `UBC_OFF_TXBUF);
	wire        rxBufRd  = rdAcc & (paddr == `UBC_OFF_RXBUF);
	wire        txShiftEmpty = txState_q == TX_IDLE;
	wire [3:0]  sampleAt = sampleSel_q ? `UBC_TICK_LAST : `UBC_TICK_MID;
	wire        txLine   = (txState_q == TX_SHIFT) ? txShift_q[0] : 1'b1;

	// flow: cts low allows sending; ignored once flow is disabled
	wire        flowOk   = flowOff | flowRts | ~syncB_q[2];
	assign flowPinOe  = ~flowOff & flowRts;
	assign flowPinOut = ~(rxEn_q & ~rxDone_q);

	// transfer clock pin is driven only as sync master
	assign clkPinOe = isSync & ~clkDir;
	assign pready   = 1'b1;

	// tx irq cause: channel 2 own bit, others shared register
	wire txCause = (CHANNEL == 2) ? txCause2_q :
		sharedCause_q[CHANNEL % 2];
	wire collEn  = (CHANNEL == 2) ? 1'b1 : irqSel_q[CHANNEL % 2];

	// start a character: enabled, data present, no write racing it
	wire txGo = (txState_q == TX_IDLE) & txEn_q & ~txBufEmpty_q &
		flowOk & (isUart | isSync) & ~txBufWr;
	wire txStep = (txState_q == TX_SHIFT) & bitTick &
		(txTick_q == `UBC_TICK_LAST);
	wire txEnd  = txStep & (txLeft_q == 4'h1);

	// collision compare once per bit while sending
	wire collHit = isBus & (txState_q == TX_SHIFT) & bitTick &
		(txTick_q == sampleAt) & (txLine != rxLevel);

	// frame assembly and receive checks
	reg  [12:0] txFrame;
	reg  [3:0]  txLen;
	reg  [3:0]  rxLen;
	reg  [8:0]  txData;
	reg  [8:0]  rxData;
	reg         txParity;
	reg         rxStop;
	reg         rxParBit;
	integer     i;

	// build start, data, optional parity, stop bits
	always @*
	begin
		txData   = isBus ? txBuf_q : {1'b0, txBuf_q[7:0]};
		// odd/even only matters while parity is enabled
		txParity = ^txData ^ ~modeReg_q[`UBC_MR_PRY];
		txFrame  = 13'h1FFF;
		if (isSync)
		begin
			txFrame[7:0] = txBuf_q[7:0];
			txLen = 4'h8;
		end
		else
		begin
			for (i = 0; i < 13; i = i + 1)
			begin
				if (i == 0)
					txFrame[i] = 1'b0;
				else if (i <= dataBits)
					txFrame[i] = txData[i - 1];
				else if (parity_enable && i == dataBits + 1)
					txFrame[i] = txParity;
			end
			txLen = dataBits + {3'h0, parity_enable} +
				{3'h0, modeReg_q[`UBC_MR_STOP2]} + 4'h2;
		end
	end

	// receive length and field extraction
	always @*
	begin
		rxLen    = isSync ? 4'h8 : dataBits + {3'h0, parity_enable} + 4'h2;
		// last sync bit is still on the line when the end sample fires
		rxData   = isBus ? rxShift_q[9:1] :
			(isSync ? {1'b0, rxLevel, rxShift_q[6:0]} :
			{1'b0, rxShift_q[8:1]});
		// stop bit is sampled in the same cycle that ends the frame
		rxStop   = rxLevel;
		rxParBit = rxShift_q[dataBits + 4'h1];
	end

	wire rxSample = (rxState_q == RX_RUN) & bitTick &
		(rxTick_q == `UBC_TICK_MID);
	wire rxEnd    = rxSample & (rxIdx_q == rxLen - 4'h1) & ~isSync |
		rxSample & isSync & (rxIdx_q == 4'h7);
	wire rxPerr   = parity_enable & ~isSync &
		(rxParBit != (^rxData ^ ~modeReg_q[`UBC_MR_PRY]));

	// baud tick generator
	ubc_baud ubc_baud_inst (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.countSource (ctrl0_q[1:0]),
		.baudDivider (baudDiv_q),
		.useExtClk   (clkDir),
		.extEdge     (extEdge),
		.bitTick     (bitTick)
	);

	// two-stage synchronisers and edge history
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			syncA_q   <= 3'h7;
			syncB_q   <= 3'h7;
			rxPrev_q  <= 1'b1;
			clkPrev_q <= 1'b1;
		end
		else
		begin
			syncA_q   <= {flowPinIn, clkPinIn, serialRxPin};
			syncB_q   <= syncA_q;
			rxPrev_q  <= rxLevel;
			clkPrev_q <= syncB_q[1];
		end
	end

	// configuration writes; collision may clear tx enable
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txBuf_q       <= `UBC_RST_WORD9;
			baudDiv_q     <= `UBC_RST_BYTE;
			modeReg_q     <= `UBC_RST_BYTE;
			ctrl0_q       <= `UBC_RST_BYTE;
			txEn_q        <= 1'b0;
			rxEn_q        <= 1'b0;
			txCause2_q    <= 1'b0;
			sampleSel_q   <= 1'b0;
			autoClr_q     <= 1'b0;
			startCond_q   <= 1'b0;
			phase_q       <= 1'b0;
			irqSel_q      <= 2'h0;
			sharedCause_q <= 2'h0;
		end
		else
		begin
			if (wrAcc)
			begin
				case (paddr)
					`UBC_OFF_TXBUF: txBuf_q <= pwdata[8:0];
					`UBC_OFF_BAUD: baudDiv_q <= pwdata[7:0];
					`UBC_OFF_MODE: modeReg_q <= pwdata[7:0];
					`UBC_OFF_CTRL0: ctrl0_q <= pwdata[7:0];
					`UBC_OFF_CTRL1:
					begin
						txEn_q     <= pwdata[`UBC_C1_TE];
						rxEn_q     <= pwdata[`UBC_C1_RE];
						txCause2_q <= pwdata[`UBC_C1_IRS];
					end
					`UBC_OFF_SPEC:
					begin
						sampleSel_q <= pwdata[`UBC_SP_COLLISION_SAMPLE_TIMING];
						autoClr_q   <= pwdata[`UBC_SP_TX_ENABLE_AUTOCLEAR];
						startCond_q <= pwdata[`UBC_SP_SSS];
						phase_q     <= pwdata[`UBC_SP_CLOCK_PHASE_SELECT];
					end
					`UBC_OFF_IRQSEL:
						irqSel_q <= {pwdata[`UBC_IS_CH1], pwdata[`UBC_IS_CH0]};
					`UBC_OFF_SHARED: sharedCause_q <= pwdata[1:0];
					default: ;
				endcase
			end
			// hardware clear wins over a same-cycle enable write
			if (collHit & autoClr_q)
				txEn_q <= 1'b0;
		end
	end

	// transmitter: wait for start condition, then shift bits
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txState_q <= TX_IDLE;
			txShift_q <= 13'h1FFF;
			txLeft_q  <= 4'h0;
			txTick_q  <= 4'h0;
		end
		else
		begin
			case (txState_q)
				TX_IDLE:
				begin
					if (txGo)
					begin
						txShift_q <= txFrame;
						txLeft_q  <= txLen;
						txTick_q  <= 4'h0;
						// with the start condition set, uart modes wait for a falling rx edge
						txState_q <= (startCond_q & isUart) ? TX_WAIT
							: TX_SHIFT;
					end
				end
				TX_WAIT:
				begin
					if (rxFall)
						txState_q <= TX_SHIFT;
				end
				TX_SHIFT:
				begin
					if (bitTick)
						txTick_q <= txTick_q + 4'h1;
					if (txEnd)
						txState_q <= TX_IDLE;
					else if (txStep)
					begin
						txShift_q <= {1'b1, txShift_q[12:1]};
						txLeft_q  <= txLeft_q - 4'h1;
					end
				end
				default: txState_q <= TX_IDLE;
			endcase
		end
	end

	// receiver: start bit in uart modes, tx-aligned in sync mode
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxState_q <= RX_IDLE;
			rxShift_q <= 13'h1FFF;
			rxIdx_q   <= 4'h0;
			rxTick_q  <= 4'h0;
		end
		else
		begin
			case (rxState_q)
				RX_IDLE:
				begin
					rxIdx_q  <= 4'h0;
					rxTick_q <= 4'h0;
					if (rxEn_q & ((isUart & rxFall) | (isSync & txGo &
						~startCond_q)))
						rxState_q <= RX_RUN;
				end
				RX_RUN:
				begin
					if (bitTick)
						rxTick_q <= rxTick_q + 4'h1;
					if (rxSample)
					begin
						rxShift_q[rxIdx_q] <= rxLevel;
						rxIdx_q <= rxIdx_q + 4'h1;
						// a start bit that is not low was a glitch
						if ((rxIdx_q == 4'h0 & rxLevel & ~isSync) | rxEnd)
							rxState_q <= RX_IDLE;
					end
					if (~rxEn_q)
						rxState_q <= RX_IDLE;
				end
				default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	// status flags; a hardware set wins over a software clear
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txBufEmpty_q <= 1'b1;
			rxDone_q     <= 1'b0;
			rxBuf_q      <= `UBC_RST_WORD9;
			ovr_q        <= 1'b0;
			frm_q        <= 1'b0;
			par_q        <= 1'b0;
			collFlag_q   <= 1'b0;
		end
		else
		begin
			// buffer empty on move into shift register
			if (txBufWr)
				txBufEmpty_q <= 1'b0;
			if (txGo)
				txBufEmpty_q <= 1'b1;
			if (rxBufRd)
				rxDone_q <= 1'b0;
			if (~rxEn_q)
			begin
				ovr_q <= 1'b0;
				frm_q <= 1'b0;
				par_q <= 1'b0;
			end
			if (rxEnd)
			begin
				if (rxDone_q & ~rxBufRd)
					ovr_q <= 1'b1;
				else
				begin
					rxBuf_q  <= rxData;
					ovr_q    <= 1'b0;
					frm_q    <= ~isSync & ~rxStop;
					par_q    <= rxPerr;
					rxDone_q <= 1'b1;
				end
			end
			if (wrAcc & (paddr == `UBC_OFF_STAT) & pwdata[0])
				collFlag_q <= 1'b0;
			if (collHit)
				collFlag_q <= 1'b1;
		end
	end

	// pin drivers: polarity, drive type and sync transfer clock
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			serialTxOut  <= 1'b1;
			serialTxOe   <= 1'b0;
			clkPinOut    <= 1'b1;
			txIrq        <= 1'b0;
			rxIrq        <= 1'b0;
			collisionIrq <= 1'b0;
		end
		else
		begin
			// open drain only pulls low, push-pull always drives
			if (ctrl0_q[`UBC_C0_NCH])
			begin
				serialTxOut <= 1'b0;
				serialTxOe  <= ~(txLine ^ invert);
			end
			else
			begin
				serialTxOut <= txLine ^ invert;
				serialTxOe  <= 1'b1;
			end
			// phase shifts by half a bit, polarity flips
			clkPinOut <= ((txState_q == TX_SHIFT) ? (txTick_q[3] ^
				phase_q) : ~phase_q) ^ ctrl0_q[`UBC_C0_CLOCK_POLARITY_SELECT];
			txIrq        <= txCause ? txEnd : txGo;
			rxIrq        <= rxEnd & ~(rxDone_q & ~rxBufRd);
			collisionIrq <= collHit & collEn;
		end
	end

	// apb read data and error, captured in the setup cycle
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setupPh)
		begin
			pslverr <= 1'b0;
			case (paddr)
				`UBC_OFF_TXBUF: prdata <= {23'h000000, txBuf_q};
				`UBC_OFF_RXBUF: prdata <= {16'h0000, ovr_q | frm_q |
					par_q, par_q, frm_q, ovr_q, 3'h0, rxBuf_q};
				`UBC_OFF_BAUD: prdata <= {24'h000000, baudDiv_q};
				`UBC_OFF_MODE: prdata <= {24'h000000, modeReg_q};
				`UBC_OFF_CTRL0: prdata <= {24'h000000, ctrl0_q[7:4],
					txShiftEmpty, ctrl0_q[2:0]};
				`UBC_OFF_CTRL1: prdata <= {27'h0000000, txCause2_q,
					rxDone_q, rxEn_q, txBufEmpty_q, txEn_q};
				`UBC_OFF_SPEC: prdata <= {22'h000000, phase_q, 2'h0,
					startCond_q, autoClr_q, sampleSel_q, 4'h0};
				`UBC_OFF_IRQSEL: prdata <= {24'h000000, irqSel_q, 6'h00};
				`UBC_OFF_STAT: prdata <= {31'h00000000, collFlag_q};
				`UBC_OFF_SHARED: prdata <= {30'h00000000, sharedCause_q};
				default:
				begin
					prdata  <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

endmodule

/* test/ubc_bus_node.sv */
// other node on the shared collision bus, wired-and with pull-up
module ubc_bus_node (
	// device transmit pin
	input  logic txOut,
	input  logic txOe,
	// this node pulls the bus low on command
	input  logic pullLow,
	// resulting bus level seen at the receive pin
	output logic busLevel
);
	timeunit 1ns;
	timeprecision 1ps;

	// a released pin floats to the pull-up level, any low wins
	assign busLevel = (txOe ? txOut : 1'b1) & ~pullLow;
endmodule

/* test/ubc_uart_sva.sv */
// port assertions for the bus collision uart
module ubc_uart_sva (
	// clock and reset
	input logic        sys_clk,
	input logic        rst,
	// apb slave
	input logic [7:0]  paddr,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// pins
	input logic        serialRxPin,
	input logic        serialTxOut,
	input logic        serialTxOe,
	input logic        clkPinIn,
	input logic        clkPinOut,
	input logic        clkPinOe,
	input logic        flowPinIn,
	input logic        flowPinOut,
	input logic        flowPinOe,
	// requests
	input logic        txIrq,
	input logic        rxIrq,
	input logic        collisionIrq
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       odQ;   // shadow of the open-drain select
	logic [2:0] modeQ; // shadow of the mode select field

	// track the settings written over apb
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			odQ   <= 1'b0;
			modeQ <= 3'h0;
		end
		else if (psel && penable && pwrite && paddr == 8'h10)
			odQ   <= pwdata[5];
		else if (psel && penable && pwrite && paddr == 8'h0C)
			modeQ <= pwdata[2:0];
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && !penable && paddr == 8'h28
		|=> pslverr) else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr == 8'h14
		|=> !pslverr) else $error("mapped access refused");
	a_err_reads_zero: assert property (psel && penable && pslverr
		|-> prdata == 32'h0) else $error("refused read returns data");
	a_rdata_stands: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved after access");
	a_od_never_high: assert property (
		odQ && $past(odQ) && $past(odQ, 2) && serialTxOe |-> !serialTxOut)
		else $error("open-drain pin drives high");
	a_pp_drives: assert property (
		!odQ && !$past(odQ) && !$past(odQ, 2) && !$past(rst) |-> serialTxOe)
		else $error("push-pull pin released");
	a_coll_bus_only: assert property (collisionIrq |-> modeQ == 3'h6)
		else $error("collision outside bus mode");
	a_coll_per_bit: assert property (
		collisionIrq |=> !collisionIrq [*8])
		else $error("collision more than once per bit");
	a_rx_once: assert property (rxIrq |=> !rxIrq [*8])
		else $error("receive request repeated");
	a_tx_pulse: assert property (txIrq |=> !txIrq)
		else $error("transmit request not a pulse");
endmodule

bind ubc_uart ubc_uart_sva ubc_uart_sva_inst (
	.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .serialRxPin(serialRxPin),
	.serialTxOut(serialTxOut), .serialTxOe(serialTxOe),
	.clkPinIn(clkPinIn), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
	.flowPinIn(flowPinIn), .flowPinOut(flowPinOut), .flowPinOe(flowPinOe),
	.txIrq(txIrq), .rxIrq(rxIrq), .collisionIrq(collisionIrq));

/* test/ubc_uart_tb.sv */
// self-checking bench of the bus collision uart
module ubc_uart_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, rst, psel, penable, pwrite; // apb master side
	logic [7:0]  paddr;                               // byte address
	logic [31:0] pwdata, prdata, rdata;               // data words
	logic        pready, pslverr, errSeen;            // answers
	logic        serialTxOut, serialTxOe, busLevel;   // shared bus
	logic        pullLow, txIrq, rxIrq, collisionIrq; // node and requests
	logic        clkPinOut, clkPinOe, flowPinOut, flowPinOe; // side pins
	int          error_cnt, check_count, collCnt, txCnt, n, i;
	int          srcT [4] = '{0, 1, 2, 3};      // count source codes
	int          baudT [4] = '{0, 1, 0, 0};     // divider values
	int          widT [4] = '{16, 64, 128, 512}; // one bit in clocks

	ubc_uart #(.CHANNEL(2)) ubc_uart_inst (.sys_clk(sys_clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialRxPin(busLevel),
		.serialTxOut(serialTxOut), .serialTxOe(serialTxOe),
		.clkPinIn(1'b0), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
		.flowPinIn(1'b0), .flowPinOut(flowPinOut), .flowPinOe(flowPinOe),
		.txIrq(txIrq), .rxIrq(rxIrq),
		.collisionIrq(collisionIrq));

	ubc_bus_node ubc_bus_node_inst (.txOut(serialTxOut),
		.txOe(serialTxOe), .pullLow(pullLow), .busLevel(busLevel));

	// free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// count collision and transmit requests
	always @(posedge sys_clk)
	begin
		if (collisionIrq === 1'b1)
			collCnt++;
		if (txIrq === 1'b1)
			txCnt++;
	end

	// compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until ready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rdata = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// bounded wait for a falling bus edge
	task waitFall;
		n = 0;
		while (busLevel !== 1'b0 && n < 2000)
		begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// clocks for which the bus stays low, bounded
	task measureLow;
		n = 0;
		while (busLevel === 1'b0 && n < 1000)
		begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// print counts and the verdict, then stop
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// cut a hang short
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		error_cnt++;
		$display("unexpected at %0t: timeout", $time);
		tally_and_finish;
	end

	// main sequence
	initial
	begin
		{psel, penable, pwrite, pullLow} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{error_cnt, check_count, collCnt, txCnt} = 0;
		rst = 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		apb(0, 8'h14, 0);
		check(rdata, 32'h2);
		apb(0, 8'h28, 0);
		check(errSeen, 1);
		check(rdata, 0);
		// bus mode, one stop bit, no parity, flow control off
		apb(1, 8'h0C, 32'h06);
		apb(1, 8'h1C, 32'hC0);
		apb(1, 8'h14, 32'h05);
		@(negedge sys_clk);
		check(flowPinOut, 0);
		// every count source, open-drain on the third
		for (i = 0; i < 4; i++)
		begin
			apb(1, 8'h10, 32'h10 | srcT[i] | (i == 2 ? 32'h20 : 0));
			apb(1, 8'h08, baudT[i]);
			apb(1, 8'h00, 32'h1A5 ^ (i << 4));
			// skip the start bit: its first tick may come early
			waitFall;
			measureLow;
			// data bit 1 is a lone zero lasting one full bit
			waitFall;
			measureLow;
			check(n, widT[i]);
			n = 0;
			while (rxIrq !== 1'b1 && n < 8000)
			begin
				@(negedge sys_clk);
				n++;
			end
			check(n < 8000, 1);
			apb(0, 8'h04, 0);
			check(rdata, 32'h1A5 ^ (i << 4));
			apb(0, 8'h14, 0);
			check(rdata & 32'h8, 0);
			repeat (widT[i]) @(posedge sys_clk);
		end
		// start waits for a falling edge on the bus
		apb(1, 8'h10, 32'h10);
		apb(1, 8'h08, 0);
		apb(1, 8'h18, 32'h40);
		apb(1, 8'h00, 32'h0FF);
		// loaded but held: the bus stays idle until someone pulls it
		n = 0;
		repeat (50)
		begin
			@(negedge sys_clk);
			if (busLevel !== 1'b1)
				n++;
		end
		check(n, 0);
		apb(0, 8'h10, 0);
		check(rdata & 32'h8, 0);
		pullLow <= 1'b1;
		repeat (2) @(posedge sys_clk);
		pullLow <= 1'b0;
		repeat (8) @(posedge sys_clk);
		apb(0, 8'h10, 0);
		check(rdata & 32'h8, 0);
		repeat (200) @(posedge sys_clk);
		apb(0, 8'h04, 0);
		// collision in mid-frame, sampled at bit end, auto-clear on
		apb(1, 8'h18, 32'h30);
		apb(0, 8'h18, 0);
		check(rdata, 32'h30);
		apb(1, 8'h00, 32'h1FF);
		waitFall;
		repeat (48) @(posedge sys_clk);
		pullLow <= 1'b1;
		repeat (40) @(posedge sys_clk);
		pullLow <= 1'b0;
		repeat (300) @(posedge sys_clk);
		check(collCnt > 0, 1);
		// low spans two bit-end samples of data bits two and three
		check(collCnt, 2);
		apb(0, 8'h14, 0);
		check(rdata & 32'h1, 0);
		apb(0, 8'h20, 0);
		check(rdata & 32'h1, 1);
		apb(1, 8'h20, 32'h1);
		apb(0, 8'h20, 0);
		check(rdata & 32'h1, 0);
		// one start-of-send request per character sent
		check(txCnt, 6);
		// sync mode idle clock level for all phase/polarity pairs
		apb(1, 8'h0C, 32'h01);
		for (i = 0; i < 4; i++)
		begin
			apb(1, 8'h10, 32'h14 | ((i & 1) << 6));
			apb(1, 8'h18, (i >> 1) << 9);
			repeat (2) @(negedge sys_clk);
			n = {2'h2, ~(i[0] ^ i[1])};
			check({clkPinOe, flowPinOe, clkPinOut}, n);
		end
		tally_and_finish;
	end
endmodule
